// >>> tpl_pkg.sv
package tpl_pkg;

    // ****************************************************************
    // Reference divider, programmable divider and receiver constants
    // ****************************************************************
    localparam int REF_DIV_LO = 512;
    localparam int REF_DIV_HI = 1024;
    localparam int REF_CNT_W = 10;
    localparam int RATIO_W = 15;
    localparam logic [14:0] RATIO_RESET = 15'h0100;
    localparam logic [4:0] CHIP_ADDR_PREFIX = 5'h18;
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [2:0] DATA_BYTES = 3'h4;
    localparam int FUNC_BIT = 7;

    // ****************************************************************
    // Register offsets on the configuration bus
    // ****************************************************************
    localparam logic [11:0] ADDR_STATUS = 12'h000;
    localparam logic [11:0] ADDR_RATIO_A = 12'h004;
    localparam logic [11:0] ADDR_RATIO_B = 12'h008;
    localparam logic [11:0] ADDR_RUN = 12'h00C;

    // ****************************************************************
    // Control byte and band byte layouts
    // ****************************************************************
    typedef struct packed {
        logic pump_current_high;
        logic test_route_en;
        logic comparator_hiz_sel;
        logic ref_ratio_sel_b;
        logic ref_ratio_sel_a;
        logic comparator_normal_sel;
        logic amp_disable;
    } tpl_ctrl_t;

    typedef struct packed {
        logic decoder_force_hi;
        logic decoder_force_lo;
        logic band_buffer_third;
        logic band_buffer_second;
        logic band_buffer_first;
    } tpl_band_t;

    localparam logic [6:0] CTRL_RESET = 7'h42;
    localparam logic [4:0] BAND_RESET = 5'h00;

    typedef enum logic [1:0] {
        DEC_LO = 2'h0,
        DEC_MID = 2'h1,
        DEC_HI = 2'h2,
        DEC_UNDEF = 2'h3
    } tpl_dec_level_t;

    typedef enum logic [1:0] {
        CMP_NORMAL = 2'h0,
        CMP_HIZ = 2'h1,
        CMP_UPPER = 2'h2,
        CMP_LOWER = 2'h3
    } tpl_cmp_mode_t;

    typedef enum logic [1:0] {
        RX_IDLE = 2'h0,
        RX_ADDR = 2'h1,
        RX_DATA = 2'h3,
        RX_SKIP = 2'h2
    } tpl_rx_state_t;

endpackage

// >>> tpl_top.sv
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ns
module tpl_top (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset,
    // Configuration bus.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Two-wire serial bus and address strap.
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [1:0] chip_addr_sel,
    // Oscillator and prescaled input pins.
    input wire logic osc_in,
    input wire logic rf_div_in,
    // Band buffers, open drain.
    output logic [2:0] band_out,
    output logic [2:0] band_oe,
    // Synthesizer controls.
    output tpl_pkg::tpl_dec_level_t band_decoder_out,
    output tpl_pkg::tpl_cmp_mode_t comparator_mode,
    output logic pump_current_high,
    output logic amp_disable,
    output logic reference_freq,
    output logic divider_out_half
);

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic [2:0] scl_q;
    logic [2:0] sda_q;
    logic [2:0] osc_q;
    logic [2:0] rf_q;
    logic [1:0] ca_s1_q;
    logic [1:0] ca_s2_q;

    // Two flops per pin; the third stage only keeps the previous level.
    always_ff @(posedge ref_clk)
    begin
        scl_q <= {scl_q[1:0], scl_in};
        sda_q <= {sda_q[1:0], sda_in};
        osc_q <= {osc_q[1:0], osc_in};
        rf_q <= {rf_q[1:0], rf_div_in};
        ca_s1_q <= chip_addr_sel;
        ca_s2_q <= ca_s1_q;
    end

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic osc_rise;
    logic rf_rise;

    // Edge and bus condition detection on the settled stages.
    assign scl_rise = scl_q[1] & ~scl_q[2];
    assign scl_fall = ~scl_q[1] & scl_q[2];
    assign start_det = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
    assign stop_det = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
    assign osc_rise = osc_q[1] & ~osc_q[2];
    assign rf_rise = rf_q[1] & ~rf_q[2];

    // ****************************************************************
    // Serial receiver
    // ****************************************************************
    tpl_pkg::tpl_rx_state_t rx_state_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic [7:0] hold_q;
    logic [2:0] data_cnt_q;
    logic ack_ok;
    logic addr_match;

    // Address is the fixed prefix, the strap bits and a write direction.
    assign addr_match = shift_q == {tpl_pkg::CHIP_ADDR_PREFIX, ca_s2_q, 1'b0};

    // Bytes beyond the fourth get no acknowledge.
    always_comb
    begin
        case (rx_state_q)
            tpl_pkg::RX_ADDR: ack_ok = addr_match;
            tpl_pkg::RX_DATA: ack_ok = data_cnt_q < tpl_pkg::DATA_BYTES;
            default: ack_ok = 1'b0;
        endcase
    end

    // Receiver state, bit counter and byte counter.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            rx_state_q <= tpl_pkg::RX_IDLE;
            bit_cnt_q <= 4'h0;
            data_cnt_q <= 3'h0;
            shift_q <= 8'h00;
            hold_q <= 8'h00;
        end
        else if (start_det)
        begin
            rx_state_q <= tpl_pkg::RX_ADDR;
            bit_cnt_q <= 4'h0;
            data_cnt_q <= 3'h0;
        end
        else if (stop_det)
        begin
            rx_state_q <= tpl_pkg::RX_IDLE;
        end
        else if (scl_rise && rx_state_q != tpl_pkg::RX_IDLE)
        begin
            if (bit_cnt_q != tpl_pkg::ACK_BIT)
            begin
                shift_q <= {shift_q[6:0], sda_q[1]};
                bit_cnt_q <= bit_cnt_q + 4'h1;
            end
            else
            begin
                bit_cnt_q <= 4'h0;
                case (rx_state_q)
                    tpl_pkg::RX_ADDR:
                    begin
                        rx_state_q <= addr_match ? tpl_pkg::RX_DATA : tpl_pkg::RX_SKIP;
                    end
                    tpl_pkg::RX_DATA:
                    begin
                        if (data_cnt_q < tpl_pkg::DATA_BYTES)
                        begin
                            data_cnt_q <= data_cnt_q + 3'h1;
                            if (!data_cnt_q[0])
                            begin
                                hold_q <= shift_q;
                            end
                        end
                    end
                    default:
                    begin
                        rx_state_q <= rx_state_q;
                    end
                endcase
            end
        end
    end

    logic pair_done;

    // Second byte of a pair completes at its acknowledge clock.
    assign pair_done = scl_rise && rx_state_q == tpl_pkg::RX_DATA && bit_cnt_q ==
        tpl_pkg::ACK_BIT && data_cnt_q < tpl_pkg::DATA_BYTES && data_cnt_q[0];

    // Acknowledge is driven from the falling edge ending the eighth bit
    // to the falling edge ending the acknowledge clock.
    always_ff @(posedge ref_clk)
    begin
        if (reset || start_det || stop_det)
        begin
            sda_oe <= 1'b0;
        end
        else if (scl_fall)
        begin
            sda_oe <= (bit_cnt_q == tpl_pkg::ACK_BIT) && ack_ok;
        end
    end

    assign sda_out = 1'b0;

    // ****************************************************************
    // Control, band and ratio latches
    // ****************************************************************
    tpl_pkg::tpl_ctrl_t ctrl_q;
    tpl_pkg::tpl_band_t band_q;
    logic [14:0] latch_a_q;
    logic [14:0] latch_b_q;
    logic div_tc;

    // The pair's leading function bit steers the update of whole pairs.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            ctrl_q <= tpl_pkg::tpl_ctrl_t'(tpl_pkg::CTRL_RESET);
            band_q <= tpl_pkg::tpl_band_t'(tpl_pkg::BAND_RESET);
            latch_a_q <= tpl_pkg::RATIO_RESET;
        end
        else if (pair_done)
        begin
            if (hold_q[tpl_pkg::FUNC_BIT])
            begin
                ctrl_q <= tpl_pkg::tpl_ctrl_t'(hold_q[6:0]);
                band_q <= {shift_q[7:5], shift_q[3], shift_q[1]};
            end
            else
            begin
                latch_a_q <= {hold_q[6:0], shift_q};
            end
        end
    end

    // Second latch copies on divider reload or any start condition.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            latch_b_q <= tpl_pkg::RATIO_RESET;
        end
        else if (div_tc || start_det)
        begin
            latch_b_q <= latch_a_q;
        end
    end

    // ****************************************************************
    // Programmable divider
    // ****************************************************************
    logic [14:0] div_cnt_q;
    logic run_q;

    // Terminal count on the input edge that reaches the end of a period.
    assign div_tc = run_q && rf_rise && div_cnt_q <= 15'h0001;

    // Count down prescaled edges; reload from the second latch at one.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            div_cnt_q <= tpl_pkg::RATIO_RESET;
            divider_out_half <= 1'b0;
        end
        else if (div_tc)
        begin
            div_cnt_q <= latch_b_q;
            divider_out_half <= ~divider_out_half;
        end
        else if (run_q && rf_rise)
        begin
            div_cnt_q <= div_cnt_q - 15'h0001;
        end
    end

    // ****************************************************************
    // Reference divider
    // ****************************************************************
    logic [9:0] ref_cnt_q;
    logic [9:0] ref_last;
    logic ref_div_1024;

    assign ref_div_1024 = ctrl_q.ref_ratio_sel_a ^ ctrl_q.ref_ratio_sel_b;
    assign ref_last = ref_div_1024 ? 10'(tpl_pkg::REF_DIV_HI - 1) :
        10'(tpl_pkg::REF_DIV_LO - 1);

    // Oscillator edges wrap at the ratio; the output is high for one edge short of half.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            ref_cnt_q <= 10'h000;
            reference_freq <= 1'b0;
        end
        else if (osc_rise)
        begin
            ref_cnt_q <= (ref_cnt_q >= ref_last) ? 10'h000 : ref_cnt_q + 10'h001;
            reference_freq <= ref_cnt_q < (ref_last >> 1);
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    function automatic tpl_pkg::tpl_dec_level_t dec_level(tpl_pkg::tpl_band_t b);
        case ({b.decoder_force_hi, b.decoder_force_lo})
            2'h1: dec_level = tpl_pkg::DEC_LO;
            2'h2: dec_level = tpl_pkg::DEC_MID;
            2'h3: dec_level = tpl_pkg::DEC_HI;
            default:
            begin
                case ({b.band_buffer_third, b.band_buffer_first})
                    2'h0: dec_level = tpl_pkg::DEC_MID;
                    2'h1: dec_level = tpl_pkg::DEC_LO;
                    2'h2: dec_level = tpl_pkg::DEC_HI;
                    default: dec_level = tpl_pkg::DEC_UNDEF;
                endcase
            end
        endcase
    endfunction

    assign band_decoder_out = dec_level(band_q);

    // Comparator mode from the normal and high impedance select bits.
    always_comb
    begin
        case ({ctrl_q.comparator_normal_sel, ctrl_q.comparator_hiz_sel})
            2'h2: comparator_mode = tpl_pkg::CMP_NORMAL;
            2'h3: comparator_mode = tpl_pkg::CMP_HIZ;
            2'h0: comparator_mode = tpl_pkg::CMP_UPPER;
            default: comparator_mode = tpl_pkg::CMP_LOWER;
        endcase
    end

    assign pump_current_high = ctrl_q.pump_current_high;
    assign amp_disable = ctrl_q.amp_disable;

    // Buffers pull low when on; test mode gates in the internal clocks.
    assign band_out = 3'h0;
    assign band_oe[0] = band_q.band_buffer_first;
    assign band_oe[1] = band_q.band_buffer_second &
        (~ctrl_q.test_route_en | ~reference_freq);
    assign band_oe[2] = band_q.band_buffer_third &
        (~ctrl_q.test_route_en | ~divider_out_half);

    // ****************************************************************
    // Configuration bus slave
    // ****************************************************************
    logic mapped;

    assign mapped = paddr == tpl_pkg::ADDR_STATUS || paddr == tpl_pkg::ADDR_RATIO_A ||
        paddr == tpl_pkg::ADDR_RATIO_B || paddr == tpl_pkg::ADDR_RUN;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // Divider run flag, written by software.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            run_q <= 1'b1;
        end
        else if (psel && penable && pwrite && paddr == tpl_pkg::ADDR_RUN)
        begin
            run_q <= pwdata[0];
        end
    end

    // Read data is captured in the setup cycle.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (psel && !penable)
        begin
            case (paddr)
                tpl_pkg::ADDR_STATUS: prdata <= {15'h0000, rx_state_q, data_cnt_q, band_q,
                    ctrl_q};
                tpl_pkg::ADDR_RATIO_A: prdata <= {17'h0_0000, latch_a_q};
                tpl_pkg::ADDR_RATIO_B: prdata <= {17'h0_0000, latch_b_q};
                tpl_pkg::ADDR_RUN: prdata <= {31'h0000_0000, run_q};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_ref_wrap: assert property (@(posedge ref_clk) disable iff (reset)
        (ctrl_q.ref_ratio_sel_a == ctrl_q.ref_ratio_sel_b && osc_rise && ref_cnt_q == 10'h1FF)
        |=> ref_cnt_q == 10'h000)
        else $error("Reference count passed 512 with equal ratio bits");
    a_test_route: assert property (@(posedge ref_clk) disable iff (reset)
        (ctrl_q.test_route_en && band_q.band_buffer_second) |-> band_oe[1] == !reference_freq)
        else $error("Reference not routed to second buffer");
    a_band_drive: assert property (@(posedge ref_clk) disable iff (reset)
        !ctrl_q.test_route_en |-> band_oe == {band_q.band_buffer_third,
        band_q.band_buffer_second, band_q.band_buffer_first})
        else $error("Band buffer drive does not follow band bits");
    a_dec_force: assert property (@(posedge ref_clk) disable iff (reset)
        (band_q.decoder_force_lo && !band_q.decoder_force_hi) |-> band_decoder_out ==
        tpl_pkg::DEC_LO)
        else $error("Decoder force low not honoured");
    a_div_reload: assert property (@(posedge ref_clk) disable iff (reset)
        div_tc |=> div_cnt_q == $past(latch_b_q))
        else $error("Divider did not reload from second latch");
    a_start_xfer: assert property (@(posedge ref_clk) disable iff (reset)
        start_det |=> latch_b_q == $past(latch_a_q))
        else $error("Start condition did not transfer ratio");
    a_reset_floor: assert property (@(posedge ref_clk)
        reset |=> latch_a_q == tpl_pkg::RATIO_RESET && rx_state_q == tpl_pkg::RX_IDLE)
        else $error("Power-on ratio or receiver state wrong");
    a_ack_limit: assert property (@(posedge ref_clk) disable iff (reset)
        (scl_fall && rx_state_q == tpl_pkg::RX_DATA && data_cnt_q == tpl_pkg::DATA_BYTES)
        |=> !sda_oe)
        else $error("Acknowledge given past the fourth data byte");
    a_pair_only: assert property (@(posedge ref_clk) disable iff (reset)
        (latch_a_q != $past(latch_a_q)) |-> $past(pair_done) &&
        !$past(hold_q[tpl_pkg::FUNC_BIT]))
        else $error("Ratio latch changed outside a complete pair");

endmodule

// >>> tpl_host.sv
`timescale 1ns/1ns
// ****************************************************************
// Two-wire bus host model
// ****************************************************************
module tpl_host (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset,
    // Bus wires.
    input wire logic sda_wire,
    output logic scl,
    output logic sda_drv
);
    // Both lines idle high, so the bus clock stands still between frames.
    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    // Waits a number of clock edges.
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // One bit: data moves while the bus clock is low and is read mid-high.
    task automatic put_bit(input logic b, output logic seen);
        sda_drv <= b;
        tick(5);
        scl <= 1'b1;
        tick(5);
        seen = sda_wire;
        tick(5);
        scl <= 1'b0;
        tick(5);
    endtask

    // Sends n bytes from the top of m and records each acknowledge.
    task automatic send(input logic [47:0] m, input int n, output logic [5:0] ack);
        logic seen;
        ack = 6'h00;
        while (reset) tick(1);
        sda_drv <= 1'b0;
        tick(10);
        scl <= 1'b0;
        tick(5);
        for (int k = 0; k < n; k++)
        begin
            for (int j = 0; j < 8; j++)
                put_bit(m[47 - 8 * k - j], seen);
            put_bit(1'b1, seen);
            ack[k] = ~seen;
        end
        sda_drv <= 1'b0;
        tick(5);
        scl <= 1'b1;
        tick(10);
        sda_drv <= 1'b1;
        tick(10);
    endtask
endmodule

// >>> testbench.sv
`timescale 1ns/1ns
// ****************************************************************
// Testbench
// ****************************************************************
module testbench;
    localparam logic [7:0] ADDR = 8'hC4;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    localparam logic [31:0] LOW12 = 32'h0000_0FFF;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic scl_in;
    logic sda_in;
    logic sda_out;
    logic sda_oe;
    logic sda_drv;
    logic [1:0] chip_addr_sel = 2'h2;
    logic osc_in = 1'b0;
    logic rf_div_in = 1'b0;
    logic rf_en = 1'b0;
    logic [2:0] band_out;
    logic [2:0] band_oe;
    tpl_pkg::tpl_dec_level_t band_decoder_out;
    tpl_pkg::tpl_cmp_mode_t comparator_mode;
    logic pump_current_high;
    logic amp_disable;
    logic reference_freq;
    logic divider_out_half;
    int fail_count = 0;
    int compares = 0;
    int osc_cnt = 0;
    int rf_cnt = 0;
    int len;
    int mism;
    logic [31:0] r;
    logic e;
    logic [5:0] ack;
    logic [7:0] bands [8] = '{8'h40, 8'h80, 8'hC0, 8'h00, 8'h02, 8'h20, 8'h08, 8'h6A};
    logic [1:0] levels [8] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h0, 2'h2, 2'h1, 2'h0};

    // The data line has a pull-up; the device only ever pulls it low.
    assign sda_in = sda_drv & (sda_oe ? sda_out : 1'b1);

    tpl_top tpl_top_inst (.ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .scl_in, .sda_in, .sda_out, .sda_oe, .chip_addr_sel,
        .osc_in, .rf_div_in, .band_out, .band_oe, .band_decoder_out, .comparator_mode,
        .pump_current_high, .amp_disable, .reference_freq, .divider_out_half);

    tpl_host tpl_host_inst (.ref_clk, .reset, .sda_wire(sda_in), .scl(scl_in), .sda_drv);

    // Clocks; the pin clocks are offset so no edge meets a clock edge.
    always #4 ref_clk = ~ref_clk;
    initial
    begin
        #2;
        forever #12 osc_in = ~osc_in;
    end
    initial
    begin
        #2;
        forever #12 rf_div_in = rf_en & ~rf_div_in;
    end
    always @(posedge osc_in) osc_cnt++;
    always @(posedge rf_div_in) rf_cnt++;

    // Compares one value and counts the outcome.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // One bus transfer; waits for the slave and releases a cycle after.
    // Only the watchdog ends a wait for an answer that never comes.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] v, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do
            @(posedge ref_clk);
        while (pready !== 1'b1);
        v = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    // Reads a register and compares the masked value.
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
        logic [31:0] v;
        logic err;
        apb(1'b0, a, 32'h0000_0000, v, err);
        check(v & m, x);
    endtask

    // Sends a control byte and a band byte.
    task automatic cfg(input logic [7:0] c, input logic [7:0] b);
        tpl_host_inst.send({ADDR, c, b, 24'h00_0000}, 3, ack);
    endtask

    // Counts pin edges between two rising edges of a divided output.
    task automatic measure(input logic which, output int n);
        int c0;
        logic prev;
        logic cur;
        c0 = -1;
        prev = 1'b1;
        n = 0;
        for (int t = 0; t < 8000 && n == 0; t++)
        begin
            @(posedge ref_clk);
            cur = which ? divider_out_half : reference_freq;
            if (!prev && cur)
            begin
                if (c0 >= 0)
                    n = (which ? rf_cnt : osc_cnt) - c0;
                else
                    c0 = which ? rf_cnt : osc_cnt;
            end
            prev = cur;
        end
    endtask

    // Prints the counts and the verdict.
    task automatic complete_run;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Cuts a hang short.
    initial
    begin
        repeat (90000) @(posedge ref_clk);
        fail_count++;
        $display("BAD %0t: watchdog expired", $time);
        complete_run();
    end

    // Main sequence.
    initial
    begin
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (6) @(posedge ref_clk);
        rd_chk(tpl_pkg::ADDR_STATUS, ALL, 32'h0000_0042);
        rd_chk(tpl_pkg::ADDR_RATIO_A, ALL, 32'h0000_0100);
        rd_chk(tpl_pkg::ADDR_RATIO_B, ALL, 32'h0000_0100);
        check(32'(band_decoder_out), 32'h0000_0001);
        check(32'(band_oe), 32'h0000_0000);
        check(32'({band_out, sda_out}), 32'h0000_0000);
        apb(1'b0, 12'h010, 32'h0000_0000, r, e);
        check(32'(e), 32'h0000_0001);
        check(r, 32'h0000_0000);
        apb(1'b1, tpl_pkg::ADDR_RUN, 32'h0000_0000, r, e);
        rd_chk(tpl_pkg::ADDR_RUN, ALL, 32'h0000_0000);
        apb(1'b1, tpl_pkg::ADDR_RUN, 32'h0000_0001, r, e);
        // A foreign chip address is neither answered nor applied.
        tpl_host_inst.send({8'hC6, 8'hFF, 8'h08, 24'h00_0000}, 3, ack);
        check(32'(ack), 32'h0000_0000);
        rd_chk(tpl_pkg::ADDR_STATUS, LOW12, 32'h0000_0042);
        // Five data bytes with the divider idle: the fifth is not answered.
        tpl_host_inst.send({ADDR, 8'h43, 8'h21, 8'hC2, 8'h0A, 8'hFF}, 6, ack);
        check(32'(ack), 32'h0000_001F);
        rd_chk(tpl_pkg::ADDR_RATIO_A, ALL, 32'h0000_4321);
        rd_chk(tpl_pkg::ADDR_RATIO_B, ALL, 32'h0000_0100);
        rd_chk(tpl_pkg::ADDR_STATUS, LOW12, 32'h0000_01C2);
        // A lone third byte is dropped; the start moves the first latch on.
        tpl_host_inst.send({ADDR, 8'h01, 8'h2C, 8'hFF, 16'h0000}, 4, ack);
        rd_chk(tpl_pkg::ADDR_RATIO_B, ALL, 32'h0000_4321);
        rd_chk(tpl_pkg::ADDR_RATIO_A, ALL, 32'h0000_012C);
        rd_chk(tpl_pkg::ADDR_STATUS, LOW12, 32'h0000_01C2);
        cfg(8'hC2, 8'h0A);
        rf_en <= 1'b1;
        measure(1'b1, len);
        measure(1'b1, len);
        check(len, 600);
        // Test routing with the second and third band bits set.
        cfg(8'hE2, 8'h28);
        mism = 0;
        repeat (3000)
        begin
            @(posedge ref_clk);
            if (band_oe[1] !== ~reference_freq || band_oe[2] !== ~divider_out_half)
                mism++;
        end
        check(mism, 0);
        check(32'(band_decoder_out), 32'h0000_0002);
        // Every setting of the two reference ratio bits.
        for (int i = 0; i < 4; i++)
        begin
            cfg({4'hC, i[1], i[0], 2'h2}, 8'h00);
            measure(1'b0, len);
            measure(1'b0, len);
            check(len, (i[1] ^ i[0]) ? 1024 : 512);
        end
        // Decoder table with comparator, pump and amplifier bits varied.
        for (int i = 0; i < 8; i++)
        begin
            cfg({1'b1, i[0], 1'b0, i[0], 2'h0, ~i[1], i[2]}, bands[i]);
            check(32'(band_decoder_out), 32'(levels[i]));
            check(32'(band_oe), 32'({bands[i][5], bands[i][3], bands[i][1]}));
            check(32'(comparator_mode), 32'(i[1:0]));
            check(32'({pump_current_high, amp_disable}), 32'({i[0], i[2]}));
        end
        complete_run();
    end
endmodule
